/* File: common/srpg_pkg.sv */
// constants and types shared by the serial register port and its helpers
package srpg_pkg;

  // ----------------------------------------------------------------
  // serial word layout
  // ----------------------------------------------------------------
  localparam logic [4:0] LAST_BIT_CNT  = 5'h0F;
  localparam int         ADDR_LSB      = 12;
  localparam int         EXT_ADDR_LSB  = 8;

  // ----------------------------------------------------------------
  // write addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_DUMMY    = 4'h0;
  localparam logic [3:0] ADDR_PRIMARY  = 4'h1;
  localparam logic [3:0] ADDR_FUNC_MIN = 4'h1;
  localparam logic [3:0] ADDR_FUNC_MAX = 4'hE;
  localparam logic [3:0] ADDR_EXT      = 4'hF;

  // ----------------------------------------------------------------
  // extended (pin) sub-addresses and their read addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] EXT_CFG_LOW   = 4'h0;
  localparam logic [3:0] EXT_CFG_HIGH  = 4'h1;
  localparam logic [3:0] EXT_PIN_DATA  = 4'h2;
  localparam logic [4:0] RD_CFG_LOW    = 5'h1B;
  localparam logic [4:0] RD_CFG_HIGH   = 5'h1C;
  localparam logic [4:0] RD_PIN_DATA   = 5'h1D;
  localparam logic [4:0] RD_ADDR_STEP  = 5'h01;

  // ----------------------------------------------------------------
  // primary control: read-address field
  // ----------------------------------------------------------------
  localparam int         RD_FIELD_LSB  = 6;
  localparam int         RD_FIELD_MSB  = 10;

  // ----------------------------------------------------------------
  // pin configuration nibble
  // ----------------------------------------------------------------
  localparam int         PIN_COUNT     = 4;
  localparam int         AUX_COUNT     = 3;
  localparam int         CFG_EN        = 3;
  localparam int         CFG_DIR       = 2;
  localparam int         CFG_POL       = 1;
  localparam int         CFG_ALEN      = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] RESET_FUNC   = 12'h000;
  localparam logic [7:0]  RESET_CFG    = 8'h00;
  localparam logic [3:0]  RESET_DATA   = 4'h0;
  localparam logic [4:0]  RESET_RADDR  = 5'h00;

  typedef enum logic [1:0] {
    SRPG_IDLE  = 2'b00,
    SRPG_SHIFT = 2'b01,
    SRPG_HOLD  = 2'b11
  } srpg_state_t;

endpackage

/* File: hdl/srpg_serial_port.sv */
// serial register port with general-purpose pin configuration
`timescale 1ns/10ps
module srpg_serial_port (
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  input  wire logic                           cs_n_pin,
  input  wire logic                           serial_shift_clock,
  input  wire logic                           din,
  output logic                                dout,
  output logic                                dout_oe,
  input  wire logic [srpg_pkg::PIN_COUNT-1:0] gpio_in,
  output logic      [srpg_pkg::PIN_COUNT-1:0] gpio_out,
  output logic      [srpg_pkg::PIN_COUNT-1:0] gpio_oe,
  output logic      [srpg_pkg::AUX_COUNT-1:0] aux_analog
);

  import srpg_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic                 cs_s;
  logic                 clk_s;
  logic                 din_s;
  logic [PIN_COUNT-1:0] pin_s;

  srpg_sync #(
    .WIDTH (PIN_COUNT + 3)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({cs_n_pin, serial_shift_clock, din, gpio_in}),
    .sync_out ({cs_s, clk_s, din_s, pin_s})
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  srpg_state_t          state;
  srpg_state_t          next_state;
  logic                 clk_d;
  logic                 next_clk_d;
  logic                 cs_d;
  logic                 next_cs_d;
  logic [4:0]           bit_cnt;
  logic [4:0]           next_bit_cnt;
  logic [15:0]          rx_word;
  logic [15:0]          next_rx_word;
  logic [15:0]          tx_word;
  logic [15:0]          next_tx_word;
  logic [4:0]           read_addr;
  logic [4:0]           next_read_addr;
  logic [11:0]          func_reg      [ADDR_FUNC_MIN:ADDR_FUNC_MAX];
  logic [11:0]          next_func_reg [ADDR_FUNC_MIN:ADDR_FUNC_MAX];
  logic [7:0]           pin_config_low;
  logic [7:0]           next_pin_config_low;
  logic [7:0]           pin_config_high;
  logic [7:0]           next_pin_config_high;
  logic [3:0]           pin_data;
  logic [3:0]           next_pin_data;
  logic                 next_dout;
  logic                 next_dout_oe;
  logic [PIN_COUNT-1:0] next_gpio_out;
  logic [PIN_COUNT-1:0] next_gpio_oe;
  logic [AUX_COUNT-1:0] next_aux_analog;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // nibble of one pin; the dedicated pin has no enable bit of its own
  function automatic logic [3:0] pin_cfg(
    input logic [7:0] lo,
    input logic [7:0] hi,
    input int         p
  );
    logic [3:0] nib;
    nib = 4'h0;
    case (p)
      0:       nib = lo[3:0];
      1:       nib = lo[7:4];
      2:       nib = hi[3:0];
      default: begin
        nib         = hi[7:4];
        nib[CFG_EN] = 1'b1;
      end
    endcase
    return nib;
  endfunction

  // pin acts as an input whose data bit follows the pin
  function automatic logic pin_is_input(input logic [3:0] nib);
    return nib[CFG_EN] & nib[CFG_DIR];
  endfunction

  // ----------------------------------------------------------------
  // read word selection
  // ----------------------------------------------------------------
  logic [15:0] rd_word;

  always_comb begin
    rd_word = 16'h0000;
    if (read_addr == RD_CFG_LOW) begin
      rd_word = {8'h00, pin_config_low};
    end else if (read_addr == RD_CFG_HIGH) begin
      rd_word = {8'h00, pin_config_high};
    end else if (read_addr == RD_PIN_DATA) begin
      rd_word = {12'h000, pin_data};
    end else if (read_addr == {1'b0, ADDR_PRIMARY}) begin
      // report the live read pointer inside the control word
      rd_word = {4'h0, func_reg[ADDR_PRIMARY][11], read_addr,
                 func_reg[ADDR_PRIMARY][RD_FIELD_LSB-1:0]};
    end else if (read_addr[4] == 1'b0 && read_addr[3:0] != ADDR_DUMMY
                 && read_addr[3:0] != ADDR_EXT) begin
      rd_word = {4'h0, func_reg[read_addr[3:0]]};
    end else begin
      // results and alert addresses are not built here, they read as zero
      rd_word = 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // link edge detection
  // ----------------------------------------------------------------
  // the link clock is sampled, never used as a clock: each of its half
  // periods must outlast the two synchroniser stages plus this stage
  logic clk_rise;
  logic clk_fall;
  logic cs_fall;

  always_comb begin
    clk_rise = clk_s & ~clk_d;
    clk_fall = ~clk_s & clk_d;
    cs_fall  = ~cs_s & cs_d;
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic [15:0] word_in;
  logic [3:0]  wr_addr;
  logic [3:0]  cfg;

  always_comb begin
    next_state           = state;
    next_clk_d           = clk_s;
    next_cs_d            = cs_s;
    next_bit_cnt         = bit_cnt;
    next_rx_word         = rx_word;
    next_tx_word         = tx_word;
    next_read_addr       = read_addr;
    next_func_reg        = func_reg;
    next_pin_config_low  = pin_config_low;
    next_pin_config_high = pin_config_high;
    next_pin_data        = pin_data;
    next_dout            = dout;
    next_dout_oe         = dout_oe;
    word_in              = {rx_word[14:0], din_s};
    wr_addr              = word_in[15:ADDR_LSB];
    cfg                  = 4'h0;

    // input pins refresh their data bit every cycle
    for (int p = 0; p < PIN_COUNT; p++) begin
      cfg = pin_cfg(pin_config_low, pin_config_high, p);
      if (pin_is_input(cfg)) begin
        next_pin_data[p] = cfg[CFG_POL] ? pin_s[p] : ~pin_s[p];
      end
    end

    case (state)
      SRPG_IDLE: begin
        next_dout_oe = 1'b0;
        if (cs_fall) begin
          next_state   = SRPG_SHIFT;
          next_bit_cnt = 5'h00;
          next_tx_word = rd_word;
          next_dout    = rd_word[15];
          next_dout_oe = 1'b1;
        end
      end

      SRPG_SHIFT: begin
        if (cs_s) begin
          // short word: nothing committed, pointer untouched
          next_state   = SRPG_IDLE;
          next_dout_oe = 1'b0;
        end else if (clk_rise) begin
          next_rx_word = word_in;
          next_bit_cnt = bit_cnt + 5'h01;
          if (bit_cnt == LAST_BIT_CNT) begin
            next_state = SRPG_HOLD;
            if (wr_addr == ADDR_EXT) begin
              case (word_in[ADDR_LSB-1:EXT_ADDR_LSB])
                EXT_CFG_LOW:  next_pin_config_low  = word_in[7:0];
                EXT_CFG_HIGH: next_pin_config_high = word_in[7:0];
                EXT_PIN_DATA: begin
                  for (int p = 0; p < PIN_COUNT; p++) begin
                    cfg = pin_cfg(pin_config_low, pin_config_high, p);
                    // input pins keep the sampled value
                    if (!pin_is_input(cfg)) begin
                      next_pin_data[p] = word_in[p];
                    end
                  end
                end
                default: ;
              endcase
            end else if (wr_addr != ADDR_DUMMY) begin
              next_func_reg[wr_addr] = word_in[11:0];
            end
            // a new read address overrides the increment
            if (wr_addr == ADDR_PRIMARY) begin
              next_read_addr = word_in[RD_FIELD_MSB:RD_FIELD_LSB];
            end else begin
              next_read_addr = read_addr + RD_ADDR_STEP;
            end
          end
        end else if (clk_fall && bit_cnt != 5'h00) begin
          next_tx_word = {tx_word[14:0], 1'b0};
          next_dout    = tx_word[14];
        end
      end

      SRPG_HOLD: begin
        // extra clocks after the word are ignored until deselect
        if (cs_s) begin
          next_state   = SRPG_IDLE;
          next_dout_oe = 1'b0;
        end
      end

      default: begin
        next_state   = SRPG_IDLE;
        next_dout_oe = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic [3:0] drv_cfg;

  always_comb begin
    next_gpio_out   = '0;
    next_gpio_oe    = '0;
    next_aux_analog = '0;
    drv_cfg         = 4'h0;
    for (int p = 0; p < PIN_COUNT; p++) begin
      drv_cfg          = pin_cfg(pin_config_low, pin_config_high, p);
      // disabled pin stays analog, other bits have no effect
      next_gpio_oe[p]  = drv_cfg[CFG_EN] & ~drv_cfg[CFG_DIR];
      next_gpio_out[p] = drv_cfg[CFG_EN] &
                         (drv_cfg[CFG_POL] ? pin_data[p] : ~pin_data[p]);
      if (p < AUX_COUNT) begin
        next_aux_analog[p] = ~drv_cfg[CFG_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // link registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state   <= SRPG_IDLE;
      clk_d   <= 1'b0;
      // matches the synchroniser's reset level, so release is no false select
      cs_d    <= 1'b0;
      bit_cnt <= 5'h00;
      rx_word <= 16'h0000;
      tx_word <= 16'h0000;
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      state   <= next_state;
      clk_d   <= next_clk_d;
      cs_d    <= next_cs_d;
      bit_cnt <= next_bit_cnt;
      rx_word <= next_rx_word;
      tx_word <= next_tx_word;
      dout    <= next_dout;
      dout_oe <= next_dout_oe;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      read_addr       <= RESET_RADDR;
      for (int i = ADDR_FUNC_MIN; i <= ADDR_FUNC_MAX; i++) begin
        func_reg[i] <= RESET_FUNC;
      end
      pin_config_low  <= RESET_CFG;
      pin_config_high <= RESET_CFG;
      pin_data        <= RESET_DATA;
    end else begin
      read_addr       <= next_read_addr;
      func_reg        <= next_func_reg;
      pin_config_low  <= next_pin_config_low;
      pin_config_high <= next_pin_config_high;
      pin_data        <= next_pin_data;
    end
  end

  // ----------------------------------------------------------------
  // pin output registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gpio_out   <= '0;
      gpio_oe    <= '0;
      aux_analog <= '1;
    end else begin
      gpio_out   <= next_gpio_out;
      gpio_oe    <= next_gpio_oe;
      aux_analog <= next_aux_analog;
    end
  end

endmodule

/* File: hdl/srpg_sync.sv */
// two-flop synchroniser bank for pins arriving from outside sys_clk
`timescale 1ns/10ps
module srpg_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // first stage feeds only the second stage
  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end

endmodule

/* File: sim/srpg_host.sv */
// host model: serial master driving select, shift clock and data
`timescale 1ns/10ps
module srpg_host (
  input  wire logic sys_clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso
);
  // half period in sys_clk cycles; raise it for a slow host
  int half = 4;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // n below 16 cuts the word short on purpose
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    cs_n <= 1'b0;
    mosi <= w[15];
    repeat (2 * half) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      r[15-i] = miso;
      repeat (half) @(posedge sys_clk);
      sclk <= 1'b0;
      if (i < 15) mosi <= w[14-i];
      repeat (half) @(posedge sys_clk);
    end
    cs_n <= 1'b1;
    // released line must not look like held data
    mosi <= ~mosi;
    repeat (2 * half) @(posedge sys_clk);
  endtask
endmodule

/* File: sim/srpg_serial_port_sva.sv */
// concurrent checks on the serial register port pins
`timescale 1ns/10ps
module srpg_serial_port_chk (
  input wire logic                           sys_clk,
  input wire logic                           rst,
  input wire logic                           cs_n_pin,
  input wire logic                           serial_shift_clock,
  input wire logic                           din,
  input wire logic                           dout,
  input wire logic                           dout_oe,
  input wire logic [srpg_pkg::PIN_COUNT-1:0] gpio_in,
  input wire logic [srpg_pkg::PIN_COUNT-1:0] gpio_out,
  input wire logic [srpg_pkg::PIN_COUNT-1:0] gpio_oe,
  input wire logic [srpg_pkg::AUX_COUNT-1:0] aux_analog
);
  import srpg_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // select framing
  // ------------------------------------------------------------
  sequence sel_fall;
    $fell(cs_n_pin) ##1 !cs_n_pin [*5];
  endsequence
  sequence idle_run;
    cs_n_pin [*8];
  endsequence
  idle_quiet_a: assert property (cs_n_pin [*5] |-> !dout_oe)
    else $error("dout enabled while deselected");
  select_drive_a: assert property (sel_fall |-> dout_oe)
    else $error("dout not enabled after select fall");
  oe_hold_a: assert property (dout_oe && !cs_n_pin |=> dout_oe)
    else $error("dout enable dropped inside a frame");
  bit_hold_a: assert property (serial_shift_clock [*5] |-> $stable(dout))
    else $error("dout moved without a clock fall");
  cfg_idle_a: assert property (idle_run |-> $stable(gpio_oe) && $stable(aux_analog))
    else $error("pin setup changed while deselected");
  // ------------------------------------------------------------
  // pin function
  // ------------------------------------------------------------
  analog_excl_a: assert property ((gpio_oe[2:0] & aux_analog) == 3'h0)
    else $error("analog pin also driven");
  analog_quiet_a: assert property ((gpio_out[2:0] & aux_analog) == 3'h0)
    else $error("analog pin shows drive value");
  reset_state_a: assert property ($fell(rst) |-> aux_analog == 3'h7 && gpio_oe == 4'h0)
    else $error("pins not in reset state");
  reset_quiet_a: assert property ($fell(rst) |-> (!dout_oe) [*4])
    else $error("dout enabled right after reset");
endmodule

bind srpg_serial_port srpg_serial_port_chk srpg_serial_port_chk_i (
  .sys_clk(sys_clk), .rst(rst), .cs_n_pin(cs_n_pin),
  .serial_shift_clock(serial_shift_clock), .din(din), .dout(dout),
  .dout_oe(dout_oe), .gpio_in(gpio_in), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .aux_analog(aux_analog)
);

/* File: sim/tb_srpg_serial_port.sv */
// self-checking bench for the serial register port
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module tb_srpg_serial_port;
  import srpg_pkg::*;
  typedef struct packed {
    logic [15:0] wr;
    logic [4:0]  ra;
    logic [15:0] exp;
  } srpg_row_t;
  logic                 sys_clk;
  logic                 rst;
  logic                 cs_n_pin;
  logic                 serial_shift_clock;
  logic                 din;
  logic                 dout;
  logic                 dout_oe;
  logic [PIN_COUNT-1:0] ext_pin;
  logic [PIN_COUNT-1:0] gpio_in;
  logic [PIN_COUNT-1:0] gpio_out;
  logic [PIN_COUNT-1:0] gpio_oe;
  logic [AUX_COUNT-1:0] aux_analog;
  logic [15:0]          rd;
  int                   fails = 0;
  int                   total_checks = 0;
  int                   cyc = 0;
  srpg_row_t rows [4] = '{'{16'h2ABC, 5'h02, 16'h0ABC}, '{16'hE123, 5'h0E, 16'h0123},
                          '{16'hF0A5, 5'h1B, 16'h00A5}, '{16'hF15A, 5'h1C, 16'h005A}};
  // driven pins read back their own level
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_pin);
  srpg_serial_port srpg_serial_port_i (
    .sys_clk(sys_clk), .rst(rst), .cs_n_pin(cs_n_pin),
    .serial_shift_clock(serial_shift_clock), .din(din), .dout(dout),
    .dout_oe(dout_oe), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .aux_analog(aux_analog)
  );
  srpg_host srpg_host_i (
    .sys_clk(sys_clk), .cs_n(cs_n_pin), .sclk(serial_shift_clock),
    .mosi(din), .miso(dout)
  );
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  task stop_test;
    $display("total_checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // point the read pointer, then a pure read
  task rd_at(input logic [4:0] a);
    srpg_host_i.xfer({4'h1, 1'b0, a, 6'h00}, 16, rd);
    srpg_host_i.xfer(16'h0000, 16, rd);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ext_pin = 4'h0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    foreach (rows[i]) begin
      srpg_host_i.xfer(rows[i].wr, 16, rd);
      rd_at(rows[i].ra);
      `CHK("row read", rows[i].exp, rd)
    end
    srpg_host_i.xfer(16'hF206, 16, rd);
    `CHK("pin oe", 4'h6, gpio_oe)
    `CHK("analog", 3'h1, aux_analog)
    `CHK("pin out", 2'h3, gpio_out[2:1])
    rd_at(5'h1D);
    `CHK("pin data", 16'h000E, rd)
    ext_pin <= 4'h8;
    rd_at(5'h1D);
    `CHK("pin input", 16'h0006, rd)
    srpg_host_i.xfer(16'hF112, 16, rd);
    `CHK("fixed pin", 1'b1, gpio_oe[3])
    `CHK("analog 2", 3'h5, aux_analog)
    srpg_host_i.xfer(16'hF208, 16, rd);
    `CHK("low pol 1", 1'b0, gpio_out[3])
    srpg_host_i.xfer(16'hF200, 16, rd);
    `CHK("low pol 0", 1'b1, gpio_out[3])
    // a write also reads and moves the pointer
    srpg_host_i.xfer(16'h3456, 16, rd);
    rd_at(5'h02);
    srpg_host_i.xfer(16'h5777, 16, rd);
    `CHK("next reg", 16'h0456, rd)
    srpg_host_i.xfer(16'h0000, 16, rd);
    srpg_host_i.xfer(16'h0000, 16, rd);
    `CHK("resume", 16'h0777, rd)
    rd_at(5'h1F);
    `CHK("top read", 16'h0000, rd)
    repeat (3) srpg_host_i.xfer(16'h0000, 16, rd);
    `CHK("wrapped", 16'h0ABC, rd)
    srpg_host_i.xfer(16'h2FFF, 8, rd);
    srpg_host_i.xfer(16'h0FFF, 16, rd);
    rd_at(5'h02);
    `CHK("short word", 16'h0ABC, rd)
    srpg_host_i.half = 7;
    srpg_host_i.xfer(16'h2321, 16, rd);
    rd_at(5'h02);
    srpg_host_i.half = 4;
    `CHK("slow host", 16'h0321, rd)
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    `CHK("reset pins", 3'h7, aux_analog)
    `CHK("reset drive", 4'h8, gpio_oe)
    rd_at(5'h02);
    `CHK("reset reg", 16'h0000, rd)
    stop_test();
  end
endmodule
